/* logic/ufc_host.sv */
// Host-side bus controller for a byte-wide parallel flash device.
// Assumes a Wishbone classic master and a flash wired to the pin ports.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Each command is one ordinary write cycle.
// - Short two-cycle programming is just fewer writes.
// - Standby command deselects chip until next cycle.
// - Three active-low strobes; never drive while reading.
// - Twenty address pins driven.
module ufc_host
   import ufc_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   output logic [ADDR_W-1:0] flash_addr,
   input wire logic [DATA_W-1:0] flash_dq_i,
   output logic [DATA_W-1:0] flash_dq_o,
   output logic flash_dq_oe,
   output logic chip_sel_n,
   output logic write_n,
   output logic out_en_n,
   output logic flash_reset_n,
   input wire logic ready_busy_n_out
);
   // ==========================================================
   // Software-visible registers and internal state
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] wdata_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] prev_rd_reg;
   logic toggled_reg;
   logic standby_reg;
   logic [1:0] op_reg;
   ufc_state_e state_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic wb_hit;
   logic wb_commit;
   logic [CNT_W-1:0] cs_low_cnt_reg;

   function automatic logic [CNT_W-1:0] cyc_of(input int n);
      cyc_of = CNT_W'(n - 1);
   endfunction : cyc_of

   // True while a bus cycle holds chip select low on the pins.
   function automatic logic in_cycle(input ufc_state_e s);
      in_cycle = (s == UFC_SETUP || s == UFC_STROBE || s == UFC_HOLD);
   endfunction : in_cycle

   // True while the read or write strobe itself is low.
   function automatic logic in_strobe(input ufc_state_e s);
      in_strobe = (s == UFC_SETUP || s == UFC_STROBE);
   endfunction : in_strobe

   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // Writes land at the edge where the master sees ack, the one edge both sides agree on.
   assign wb_commit = wb_cyc_i && wb_stb_i && wb_ack_o;

   wire busy = (state_reg != UFC_IDLE);

   always_ff @(posedge clock) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_hit;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         addr_reg <= '0;
         wdata_reg <= '0;
      end else if (wb_commit && wb_we_i && !busy) begin
         if (wb_adr_i == REG_ADDR && wb_sel_i[0]) addr_reg[7:0] <= wb_dat_i[7:0];
         if (wb_adr_i == REG_ADDR && wb_sel_i[1]) addr_reg[15:8] <= wb_dat_i[15:8];
         if (wb_adr_i == REG_ADDR && wb_sel_i[2]) addr_reg[19:16] <= wb_dat_i[19:16];
         if (wb_adr_i == REG_DATA && wb_sel_i[0]) wdata_reg <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         wb_dat_o <= '0;
      end else begin
         case (wb_adr_i)
            REG_ADDR: wb_dat_o <= {12'h000, addr_reg};
            REG_DATA: wb_dat_o <= {24'h000000, wdata_reg};
            REG_RDATA: wb_dat_o <= {24'h000000, rdata_reg};
            REG_STAT: begin
               wb_dat_o <= '0;
               wb_dat_o[ST_BUSY_BIT] <= busy;
               wb_dat_o[ST_RYBY_BIT] <= ready_busy_n_out;
               wb_dat_o[ST_STBY_BIT] <= standby_reg;
               wb_dat_o[ST_POLL_BIT] <= rdata_reg[POLL_BIT];
               wb_dat_o[ST_TOGL_BIT] <= toggled_reg;
            end
            default: wb_dat_o <= '0;
         endcase
      end
   end

   // ==========================================================
   // Pin sequencer
   // Writes arriving while a cycle runs are acked but dropped; software polls busy first.
   wire cmd_go = wb_commit && wb_we_i && wb_sel_i[0]
                 && (wb_adr_i == REG_CMD) && !busy;

   always_ff @(posedge clock) begin
      if (reset) begin
         state_reg <= UFC_IDLE;
         cnt_reg <= '0;
         op_reg <= '0;
      end else begin
         case (state_reg)
            UFC_IDLE: begin
               if (cmd_go && wb_dat_i[CMD_RST_BIT]) begin
                  state_reg <= UFC_RESET;
                  cnt_reg <= cyc_of(RST_CYC);
               end else if (cmd_go && (wb_dat_i[1:0] == CMD_READ
                                       || wb_dat_i[1:0] == CMD_WRITE)) begin
                  state_reg <= UFC_SETUP;
                  op_reg <= wb_dat_i[1:0];
               end
            end
            UFC_SETUP: begin
               state_reg <= UFC_STROBE;
               cnt_reg <= (op_reg == CMD_READ) ? cyc_of(ACC_CYC) : cyc_of(WP_CYC);
            end
            UFC_STROBE: begin
               if (cnt_reg == '0) state_reg <= UFC_HOLD;
               else cnt_reg <= cnt_reg - 1'b1;
            end
            UFC_HOLD: state_reg <= UFC_IDLE;
            UFC_RESET: begin
               if (cnt_reg == '0) state_reg <= UFC_IDLE;
               else cnt_reg <= cnt_reg - 1'b1;
            end
            default: state_reg <= UFC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         standby_reg <= 1'b0;
      end else if (cmd_go && wb_dat_i[1:0] == CMD_STBY) begin
         standby_reg <= 1'b1;
      end else if (state_reg == UFC_SETUP) begin
         standby_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Pin drivers
   always_ff @(posedge clock) begin
      if (reset) begin
         flash_reset_n <= 1'b1;
      end else begin
         flash_reset_n <= !(state_reg == UFC_RESET);
      end
   end

   // Address only changes on a new cycle, so the device can fall asleep in between.
   always_ff @(posedge clock) begin
      if (reset) begin
         flash_addr <= '0;
         flash_dq_o <= '0;
      end else if (state_reg == UFC_SETUP) begin
         flash_addr <= addr_reg;
         flash_dq_o <= wdata_reg;
      end
   end

   // Chip select and data outlast the write strobe by a cycle, so the latch sees clean data.
   always_ff @(posedge clock) begin
      if (reset) begin
         chip_sel_n <= 1'b1;
         write_n <= 1'b1;
         out_en_n <= 1'b1;
      end else begin
         chip_sel_n <= !in_cycle(state_reg);
         write_n <= !(in_strobe(state_reg) && op_reg == CMD_WRITE);
         out_en_n <= !(in_strobe(state_reg) && op_reg == CMD_READ);
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         flash_dq_oe <= 1'b0;
      end else begin
         flash_dq_oe <= in_cycle(state_reg) && op_reg == CMD_WRITE;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         rdata_reg <= '0;
         prev_rd_reg <= '0;
         toggled_reg <= 1'b0;
      end else if (state_reg == UFC_HOLD && op_reg == CMD_READ) begin
         rdata_reg <= flash_dq_i;
         prev_rd_reg <= rdata_reg;
         toggled_reg <= flash_dq_i[TOGL_BIT] != rdata_reg[TOGL_BIT];
      end
   end

   // ==========================================================
   // Checks
   no_contention_a: assert property (@(posedge clock) disable iff (reset)
      !(flash_dq_oe && !out_en_n)) else $error("data driven during read");
   write_shape_a: assert property (@(posedge clock) disable iff (reset)
      !write_n |-> (!chip_sel_n && out_en_n)) else $error("bad write strobes");
   read_shape_a: assert property (@(posedge clock) disable iff (reset)
      !out_en_n |-> (!chip_sel_n && write_n)) else $error("bad read strobes");
   reset_pulse_a: assert property (@(posedge clock) disable iff (reset)
      $fell(flash_reset_n) |-> !flash_reset_n [*8]) else $error("reset pulse short");
   write_launch_a: assert property (@(posedge clock) disable iff (reset)
      (state_reg == UFC_SETUP && op_reg == CMD_WRITE) |=> (!write_n && flash_dq_o == wdata_reg))
      else $error("write not launched");
   addr_stable_a: assert property (@(posedge clock) disable iff (reset)
      (state_reg == UFC_IDLE) |=> $stable(flash_addr)) else $error("address moved idle");
   read_done_a: assert property (@(posedge clock) disable iff (reset)
      (state_reg == UFC_SETUP && op_reg == CMD_READ) |-> ##[12:16] (state_reg == UFC_IDLE))
      else $error("read cycle length");
   addr_drive_a: assert property (@(posedge clock) disable iff (reset)
      $fell(chip_sel_n) |-> (flash_addr == addr_reg)) else $error("address not driven");

   // Counts how long chip select has been low; no cycle may hold it more than two cycles past the read access.
   always_ff @(posedge clock) begin
      if (reset) begin
         cs_low_cnt_reg <= '0;
      end else if (chip_sel_n) begin
         cs_low_cnt_reg <= '0;
      end else begin
         cs_low_cnt_reg <= cs_low_cnt_reg + 1'b1;
      end
   end

   cs_len_a: assert property (@(posedge clock) disable iff (reset)
      cs_low_cnt_reg <= CNT_W'(ACC_CYC + 2)) else $error("chip select held too long");
   write_len_a: assert property (@(posedge clock) disable iff (reset)
      (state_reg == UFC_SETUP && op_reg == CMD_WRITE) |-> ##[6:8] (state_reg == UFC_IDLE))
      else $error("write cycle length");
   reset_len_a: assert property (@(posedge clock) disable iff (reset)
      (state_reg == UFC_IDLE && cmd_go && wb_dat_i[CMD_RST_BIT])
      |-> ##[50:52] (state_reg == UFC_IDLE)) else $error("reset pulse length");
   reset_quiet_a: assert property (@(posedge clock) disable iff (reset)
      !flash_reset_n |-> chip_sel_n) else $error("chip selected during reset");
   data_hold_a: assert property (@(posedge clock) disable iff (reset)
      $rose(write_n) |-> (flash_dq_oe && !chip_sel_n)) else $error("write data not held");
   dq_oe_shape_a: assert property (@(posedge clock) disable iff (reset)
      flash_dq_oe |-> (!chip_sel_n && out_en_n)) else $error("data driven outside write");
   idle_quiet_a: assert property (@(posedge clock) disable iff (reset)
      (state_reg == UFC_IDLE) |=> (write_n && out_en_n)) else $error("strobe low when idle");
   standby_idle_a: assert property (@(posedge clock) disable iff (reset)
      standby_reg |-> chip_sel_n) else $error("chip selected in standby");
   read_sample_a: assert property (@(posedge clock) disable iff (reset)
      (state_reg == UFC_HOLD && op_reg == CMD_READ) |=> (rdata_reg == $past(flash_dq_i)))
      else $error("read byte not captured");

   // ==========================================================
   // Bus handshake checks
   ack_pulse_a: assert property (@(posedge clock) disable iff (reset)
      wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   ack_answer_a: assert property (@(posedge clock) disable iff (reset)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack not given");
   busy_drop_a: assert property (@(posedge clock) disable iff (reset)
      (busy && wb_commit && wb_we_i) |=> ($stable(addr_reg) && $stable(wdata_reg)))
      else $error("register written while busy");
endmodule : ufc_host
`default_nettype wire

/* logic/ufc_pkg.sv */
// Package for the host-side flash bus controller: register map, pin timing and states.
// Assumes a single 100 MHz clock domain and a classic Wishbone slave port.
package ufc_pkg;
   // ==========================================================
   // Device geometry
   localparam int ADDR_W = 20;
   localparam int DATA_W = 8;
   localparam int SECT_W = 4;
   // ==========================================================
   // Register offsets, byte addresses on the Wishbone bus
   localparam logic [7:0] REG_ADDR = 8'h00;
   localparam logic [7:0] REG_DATA = 8'h04;
   localparam logic [7:0] REG_CMD = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0c;
   localparam logic [7:0] REG_RDATA = 8'h10;
   // Command register field values.
   localparam logic [1:0] CMD_READ = 2'h1;
   localparam logic [1:0] CMD_WRITE = 2'h2;
   localparam logic [1:0] CMD_STBY = 2'h3;
   // Command and status bit positions.
   localparam int CMD_RST_BIT = 2;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_RYBY_BIT = 1;
   localparam int ST_STBY_BIT = 2;
   localparam int ST_POLL_BIT = 3;
   localparam int ST_TOGL_BIT = 4;
   localparam int POLL_BIT = 7;
   localparam int TOGL_BIT = 6;
   // ==========================================================
   // Pin timing, in ns and cycles at 100 MHz
   localparam int CLK_NS = 10;
   localparam int T_ACC_NS = 120;
   localparam int T_WP_NS = 50;
   localparam int T_RST_NS = 500;
   localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int RST_CYC = (T_RST_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 8;
   // ==========================================================
   // Bus cycle states
   typedef enum logic [2:0] {
      UFC_IDLE = 3'h0,
      UFC_SETUP = 3'h1,
      UFC_STROBE = 3'h3,
      UFC_HOLD = 3'h2,
      UFC_RESET = 3'h6
   } ufc_state_e;
endpackage : ufc_pkg

/* dv/ufc_flash_model.sv */
// Behavioural byte-wide flash device seen from the host controller's pins.
// Assumes a single host drives the strobes; the clock only times the busy span.
`timescale 1ns/1ps
`default_nettype none
module ufc_flash_model #(
   parameter int BUSY_CYC = 150
) (
   input wire logic clock,
   input wire logic [19:0] flash_addr,
   input wire logic [7:0] host_dq,
   input wire logic chip_sel_n,
   input wire logic write_n,
   input wire logic out_en_n,
   input wire logic flash_reset_n,
   output logic [7:0] dev_dq,
   output logic ready_busy_n_out
);
   // =============================================
   // Array and internal algorithm
   logic [7:0] mem [logic [19:0]];
   logic [7:0] prog_d = 8'h00;
   logic [7:0] last_q = 8'h00;
   logic tog_q = 1'b0;
   int busy = 0;
   always @(posedge write_n) begin
      // No protection, suspend or supply model: every write is taken unless the reset pin is low.
      if (!chip_sel_n && flash_reset_n) begin
         prog_d = host_dq;
         // Only the addressed byte changes, and bits are only ever cleared.
         mem[flash_addr] = (mem.exists(flash_addr) ? mem[flash_addr] : 8'hff) & host_dq;
         busy = BUSY_CYC;
      end
   end
   always @(posedge clock) begin
      if (!flash_reset_n) begin
         busy = 0;
      end else if (busy > 0) begin
         busy = busy - 1;
      end
   end
   always @(negedge out_en_n) begin
      if (busy > 0) begin
         tog_q = ~tog_q;
      end
   end
   always @(posedge out_en_n) begin
      last_q = dev_dq;
   end
   // A released bus shows the inverse of the last byte, never a helpful copy.
   always @* begin
      if (!chip_sel_n && !out_en_n && write_n) begin
         if (busy > 0) begin
            dev_dq = {~prog_d[7], tog_q, 6'h00};
         end else begin
            dev_dq = mem.exists(flash_addr) ? mem[flash_addr] : 8'hff;
         end
      end else begin
         dev_dq = ~last_q;
      end
   end
   assign ready_busy_n_out = (busy == 0);
endmodule : ufc_flash_model
`default_nettype wire

/* dv/tb_uniform_sector_flash_command_fsm.sv */
// Self-checking bench for the host-side flash controller.
// Assumes the flash model in its own file and the controller's Wishbone map.
`timescale 1ns/1ps
`default_nettype none
module tb_uniform_sector_flash_command_fsm;
   import ufc_pkg::*;
   logic clock = 0, reset = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic [3:0] wb_sel_i = 4'h0;
   logic wb_ack_o, flash_dq_oe, chip_sel_n, write_n, out_en_n, flash_reset_n, ready_busy_n_out;
   logic [19:0] flash_addr;
   logic [7:0] flash_dq_o, dev_dq;
   wire logic [7:0] dq_wire = flash_dq_oe ? flash_dq_o : dev_dq;
   int errors = 0, num_checks = 0;
   ufc_host dut (.clock(clock), .reset(reset), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .flash_addr(flash_addr),
      .flash_dq_i(dq_wire), .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe),
      .chip_sel_n(chip_sel_n), .write_n(write_n), .out_en_n(out_en_n),
      .flash_reset_n(flash_reset_n), .ready_busy_n_out(ready_busy_n_out));
   ufc_flash_model #(.BUSY_CYC(150)) flash (.clock(clock), .flash_addr(flash_addr),
      .host_dq(dq_wire), .chip_sel_n(chip_sel_n), .write_n(write_n), .out_en_n(out_en_n),
      .flash_reset_n(flash_reset_n), .dev_dq(dev_dq), .ready_busy_n_out(ready_busy_n_out));
   // =============================================
   // Shared tasks
   initial begin
      forever #5 clock = ~clock;
   end
   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Called at a rising edge; returns at a rising edge after one idle cycle.
   task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
      input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      @(posedge clock);
      while (wb_ack_o !== 1'b1 && n < 50) begin
         @(posedge clock);
         n++;
      end
      if (wb_ack_o !== 1'b1) begin
         errors++;
         final_report();
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clock);
   endtask : wb
   // Waits on a status bit with a bounded number of reads.
   task automatic wait_stat(input int bitn, input logic val);
      int n;
      n = 0;
      wb(0, REG_STAT, 4'hf, 0);
      while (q[bitn] !== val && n < 100) begin
         wb(0, REG_STAT, 4'hf, 0);
         n++;
      end
      if (q[bitn] !== val) begin
         errors++;
         final_report();
      end
   endtask : wait_stat
   // =============================================
   // Scenarios
   task automatic t_idle;
      chk("idle strobes", 4'hf, {chip_sel_n, write_n, out_en_n, flash_reset_n});
      wb(0, REG_STAT, 4'hf, 0);
      chk("stat idle", 3'b010, q[2:0]);
      wb(1, 8'h20, 4'hf, 32'h5a);
      wb(0, 8'h20, 4'hf, 0);
      chk("unmapped", 0, q);
   endtask : t_idle
   task automatic t_program(input logic [7:0] d);
      wb(1, REG_ADDR, 4'h7, 32'h5a5a5);
      wb(1, REG_DATA, 4'h1, {24'h0, d});
      wb(1, REG_CMD, 4'hf, {30'h0, CMD_WRITE});
      repeat (2) @(posedge clock);
      chk("write strobes", 3'b001, {chip_sel_n, write_n, out_en_n});
      chk("write pins", {1'b1, 20'h5a5a5, d}, {flash_dq_oe, flash_addr, flash_dq_o});
      wait_stat(ST_BUSY_BIT, 1'b0);
   endtask : t_program
   task automatic t_read;
      wb(1, REG_CMD, 4'hf, {30'h0, CMD_READ});
      repeat (2) @(posedge clock);
      chk("read strobes", 4'b0100, {chip_sel_n, write_n, out_en_n, flash_dq_oe});
      wait_stat(ST_BUSY_BIT, 1'b0);
   endtask : t_read
   task automatic t_status;
      t_program(8'h3c);
      chk("ready pin busy", 0, q[ST_RYBY_BIT]);
      t_read();
      t_read();
      chk("poll and toggle", 2'b11, {q[ST_TOGL_BIT], q[ST_POLL_BIT]});
      wait_stat(ST_RYBY_BIT, 1'b1);
      t_read();
      wb(0, REG_RDATA, 4'hf, 0);
      chk("array data", 32'h3c, q);
   endtask : t_status
   task automatic t_reset;
      t_program(8'h0f);
      wb(1, REG_CMD, 4'hf, 32'h4);
      repeat (2) @(posedge clock);
      chk("reset pin low", 0, flash_reset_n);
      wb(1, REG_ADDR, 4'h7, 32'h12345);
      wb(0, REG_ADDR, 4'hf, 0);
      chk("addr while busy", 32'h5a5a5, q);
      wait_stat(ST_BUSY_BIT, 1'b0);
      chk("reset aborts", 2'b11, {flash_reset_n, q[ST_RYBY_BIT]});
      wb(1, REG_CMD, 4'hf, {30'h0, CMD_STBY});
      wait_stat(ST_BUSY_BIT, 1'b0);
      chk("standby", 2'b11, {chip_sel_n, q[ST_STBY_BIT]});
   endtask : t_reset
   initial begin
      #200000;
      errors++;
      final_report();
   end
   initial begin
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      t_idle();
      t_status();
      t_reset();
      final_report();
   end
endmodule : tb_uniform_sector_flash_command_fsm
`default_nettype wire
